// ==== logic/cwpd_config_decode.sv ====
// Purpose: decode the non-volatile configuration word and serve it over AXI4-Lite
// Assumes: all inputs are on aclk
// Notes:   settings are taken only at load and at programming exit
// What this block does
// - one 14-bit configuration word at 2007h
// - 256-word self-write protection ranges by code
// - 512-word self-write protection ranges by code
// - bit 10 set selects low trip point
// - bit 9 enables low-power brown-out reset
// - bit 8 allows low-voltage programming, forces reset pin
// - otherwise bit 6 picks reset or digital input
// - active-low protect blocks external writes, reads zero
// - processor reads always; self-writes follow protection field
// - code protection cleared only by bulk erase
// - program protection only; data memory has no protection here
// - power-up timer enable is active low, separate
// - watchdog mode field decoded four ways
// - brown-out mode field; soft bit only code 01
// - bit 0 selects external clock or internal oscillator
// - four user ID words, freely read and written
// - identification word: device code and revision
// - identification word ignores writes
//
// Added by the designer: the AXI4-Lite slave port.
`include "cwpd_config_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cwpd_config_decode
  import cwpd_pkg::*;
#(
  parameter int unsigned MEM_WORDS   = 256,
  // arbitrary neutral identification values
  parameter logic [8:0]  DEVICE_CODE = 9'h0C3,
  parameter logic [4:0]  REVISION    = 5'h01
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [15:0]                  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  // axi4-lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // axi4-lite read address
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [15:0]                  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  // axi4-lite read data
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // non-volatile word and live controls
  input  wire logic [13:0]                  nv_config_word,
  input  wire logic                         cpu_sleep,
  input  wire logic                         soft_watchdog_enable,
  input  wire logic                         soft_brownout_enable,
  input  wire logic                         pin3_pullup_enable,
  // self-write check
  input  wire logic [$clog2(MEM_WORDS)-1:0] self_wr_addr,
  output logic                              self_wr_allow,
  // decoded settings
  output logic                              sys_reset_n,
  output logic                              brownout_trip_low,
  output logic                              low_power_brownout_en,
  output logic                              low_voltage_prog_en,
  output logic                              reset_pin_is_reset,
  output logic                              reset_pin_pullup_en,
  output logic                              powerup_timer_en,
  output logic                              watchdog_active,
  output logic                              brownout_active,
  output logic                              external_clock_mode,
  output logic                              ext_write_allow,
  output logic                              ext_read_zero
);

  localparam int unsigned PA_W = $clog2(MEM_WORDS);
  localparam logic [PA_W:0] LIM_QUARTER = (PA_W+1)'(MEM_WORDS / 4);
  localparam logic [PA_W:0] LIM_HALF    = (PA_W+1)'(MEM_WORDS / 2);
  localparam logic [13:0]   DEV_REV_WORD = {DEVICE_CODE, REVISION};

  generate
    if (MEM_WORDS != 256 && MEM_WORDS != 512) begin : g_bad_size
      $error("MEM_WORDS must be 256 or 512");
    end
  endgenerate

  cwpd_state_t state_q;
  logic [13:0] image_q;
  logic [13:0] cfg_q;
  logic [13:0] uid_q [4];
  logic        sys_reset_n_q;

  logic        aw_held_q;
  logic [13:0] aw_idx_q;
  logic        w_held_q;
  logic [13:0] wdata_q;
  logic [1:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // write path: address and data are caught separately, in any order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  logic do_wr;
  logic wr_uid;
  logic wr_cfg;
  logic wr_pc;
  logic wr_known;
  logic [13:0] wr_merged;
  logic bulk_go;
  logic prog_enter;
  logic prog_exit;

  assign do_wr = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    wr_uid   = 1'b0;
    wr_cfg   = 1'b0;
    wr_pc    = 1'b0;
    wr_known = 1'b1;
    if (aw_idx_q >= `CWPD_IDX_USER_ID0 && aw_idx_q <= `CWPD_IDX_USER_ID3) begin
      wr_uid = do_wr;
    end else if (aw_idx_q == `CWPD_IDX_CONFIG_WORD) begin
      wr_cfg = do_wr;
    end else if (aw_idx_q == `CWPD_IDX_PROG_CONTROL) begin
      wr_pc = do_wr;
    end else if (aw_idx_q == `CWPD_IDX_DEVICE_REV_ID || aw_idx_q == `CWPD_IDX_ACTIVE_CONFIG) begin
      wr_known = 1'b1;  // read-only: write taken and dropped
    end else begin
      wr_known = 1'b0;
    end
  end

  function automatic logic [13:0] lane_merge(input logic [13:0] old_v, input logic [13:0] new_v,
                                             input logic [1:0] strb);
    logic [13:0] r;
    r       = old_v;
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      r[13:8] = new_v[13:8];
    end
    return r;
  endfunction

  assign wr_merged  = lane_merge(image_q, wdata_q, wstrb_q);
  assign bulk_go    = wr_pc && wstrb_q[0] && wdata_q[`CWPD_PC_BULK_ERASE] && state_q == CWPD_ST_PROG;
  assign prog_enter = wr_pc && wstrb_q[0] && wdata_q[`CWPD_PC_PROG_MODE] && state_q == CWPD_ST_RUN;
  assign prog_exit  = wr_pc && wstrb_q[0] && !wdata_q[`CWPD_PC_PROG_MODE] && state_q == CWPD_ST_PROG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 14'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[15:2];
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 14'h0000;
      wstrb_q  <= 2'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata[13:0];
      wstrb_q  <= s_axi_wstrb[1:0];
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CWPD_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? `CWPD_RESP_OKAY : `CWPD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read path: one cycle from address to data
  logic [13:0] rd_idx;
  logic [31:0] rd_val;
  logic        rd_known;

  assign rd_idx = s_axi_araddr[15:2];

  always_comb begin
    rd_val   = 32'h0000_0000;
    rd_known = 1'b1;
    if (rd_idx >= `CWPD_IDX_USER_ID0 && rd_idx <= `CWPD_IDX_USER_ID3) begin
      rd_val = {18'h00000, uid_q[rd_idx[1:0]]};
    end else if (rd_idx == `CWPD_IDX_DEVICE_REV_ID) begin
      rd_val = {18'h00000, DEV_REV_WORD};
    end else if (rd_idx == `CWPD_IDX_CONFIG_WORD) begin
      rd_val = {18'h00000, image_q};
    end else if (rd_idx == `CWPD_IDX_PROG_CONTROL) begin
      rd_val = {31'h0000_0000, state_q == CWPD_ST_PROG};
    end else if (rd_idx == `CWPD_IDX_ACTIVE_CONFIG) begin
      rd_val = {18'h00000, cfg_q};
    end else begin
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `CWPD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_known ? `CWPD_RESP_OKAY : `CWPD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // load, settle, run, programming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CWPD_ST_LOAD;
    end else begin
      case (state_q)
        CWPD_ST_LOAD:   state_q <= CWPD_ST_SETTLE;
        CWPD_ST_SETTLE: state_q <= CWPD_ST_RUN;
        CWPD_ST_RUN:    state_q <= prog_enter ? CWPD_ST_PROG : CWPD_ST_RUN;
        CWPD_ST_PROG:   state_q <= prog_exit ? CWPD_ST_RUN : CWPD_ST_PROG;
        default:        state_q <= CWPD_ST_LOAD;
      endcase
    end
  end

  // core held in reset until outputs reflect cfg_q, and while programming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_n_q <= 1'b0;
    end else begin
      sys_reset_n_q <= state_q == CWPD_ST_RUN;
    end
  end
  assign sys_reset_n = sys_reset_n_q;

  // non-volatile image: programming only clears bits, so protection can only tighten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      image_q <= `CWPD_CFG_ERASED;
    end else if (state_q == CWPD_ST_LOAD) begin
      image_q <= nv_config_word | 14'h2000;
    end else if (bulk_go) begin
      image_q <= `CWPD_CFG_ERASED;
    end else if (wr_cfg && state_q == CWPD_ST_PROG) begin
      image_q <= (image_q & wr_merged) | 14'h2000;
    end
  end

  // active settings are frozen while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `CWPD_CFG_ERASED;
    end else if (state_q == CWPD_ST_LOAD) begin
      cfg_q <= nv_config_word | 14'h2000;
    end else if (prog_exit) begin
      cfg_q <= image_q;
    end
  end

  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_uid
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          uid_q[gi] <= `CWPD_UID_ERASED;
        end else if (bulk_go) begin
          uid_q[gi] <= `CWPD_UID_ERASED;
        end else if (wr_uid && aw_idx_q[1:0] == 2'(gi)) begin
          uid_q[gi] <= lane_merge(uid_q[gi], wdata_q, wstrb_q);
        end
      end
    end
  endgenerate

  // self-write range check; processor reads are never gated here
  logic [1:0]    wrt_sel;
  logic [PA_W:0] sw_addr;
  logic          sw_ok;

  assign wrt_sel = cfg_q[`CWPD_CFG_WRT_HI:`CWPD_CFG_WRT_LO];
  assign sw_addr = {1'b0, self_wr_addr};

  always_comb begin
    case (wrt_sel)
      `CWPD_WRT_OFF:     sw_ok = 1'b1;
      `CWPD_WRT_QUARTER: sw_ok = sw_addr >= LIM_QUARTER;
      `CWPD_WRT_HALF:    sw_ok = sw_addr >= LIM_HALF;
      default:           sw_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      self_wr_allow <= 1'b0;
    end else begin
      self_wr_allow <= sw_ok && sys_reset_n_q;
    end
  end

  function automatic logic mode_active(input logic [1:0] m, input logic sleep_i, input logic soft_i);
    case (m)
      `CWPD_MODE_ON:       return 1'b1;
      `CWPD_MODE_RUN_ONLY: return !sleep_i;
      `CWPD_MODE_SOFT:     return soft_i;
      default:             return 1'b0;
    endcase
  endfunction

  // decoded settings, from the frozen word and the live controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brownout_trip_low     <= 1'b0;
      low_power_brownout_en <= 1'b0;
      low_voltage_prog_en   <= 1'b0;
      reset_pin_is_reset    <= 1'b1;
      reset_pin_pullup_en   <= 1'b1;
      powerup_timer_en      <= 1'b0;
      watchdog_active       <= 1'b0;
      brownout_active       <= 1'b0;
      external_clock_mode   <= 1'b0;
      ext_write_allow       <= 1'b0;
      ext_read_zero         <= 1'b1;
    end else begin
      brownout_trip_low     <= cfg_q[`CWPD_CFG_BROWNOUT_TRIP_SELECT];
      low_power_brownout_en <= cfg_q[`CWPD_CFG_LOW_POWER_BROWNOUT_EN];
      low_voltage_prog_en   <= cfg_q[`CWPD_CFG_LVP];
      if (cfg_q[`CWPD_CFG_LVP]) begin
        reset_pin_is_reset  <= 1'b1;
        reset_pin_pullup_en <= 1'b1;
      end else if (cfg_q[`CWPD_CFG_RESET_PIN_FUNCTION_SEL]) begin
        reset_pin_is_reset  <= 1'b1;
        reset_pin_pullup_en <= 1'b1;
      end else begin
        reset_pin_is_reset  <= 1'b0;
        reset_pin_pullup_en <= pin3_pullup_enable;
      end
      // power-up timer is independent of the brown-out fields
      powerup_timer_en      <= !cfg_q[`CWPD_CFG_POWERUP_TIMER_EN_N_N];
      watchdog_active       <= mode_active(cfg_q[`CWPD_CFG_WDTE_HI:`CWPD_CFG_WDTE_LO],
                                           cpu_sleep, soft_watchdog_enable);
      brownout_active       <= mode_active(cfg_q[`CWPD_CFG_BOREN_HI:`CWPD_CFG_BOREN_LO],
                                           cpu_sleep, soft_brownout_enable);
      external_clock_mode   <= cfg_q[`CWPD_CFG_FOSC];
      // only external program-memory access is gated; data memory has no gate here
      ext_write_allow       <= cfg_q[`CWPD_CFG_CP_N];
      ext_read_zero         <= !cfg_q[`CWPD_CFG_CP_N];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic live;
  logic live_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_q <= 1'b0;
    end else begin
      live_q <= sys_reset_n_q;
    end
  end
  assign live = sys_reset_n_q && live_q;

  property p_cfg_frozen;
    (state_q == CWPD_ST_RUN && $past(state_q) == CWPD_ST_RUN) |-> $stable(cfg_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("active config changed while running");

  property p_cp_blocks;
    live |-> (ext_write_allow == $past(cfg_q[`CWPD_CFG_CP_N])) && (ext_read_zero != ext_write_allow);
  endproperty
  a_cp_blocks: assert property (p_cp_blocks) else $error("code protection gating wrong");

  property p_cp_only_bulk;
    $rose(image_q[`CWPD_CFG_CP_N]) |-> $past(bulk_go);
  endproperty
  a_cp_only_bulk: assert property (p_cp_only_bulk) else $error("protection cleared without bulk erase");

  property p_device_revision_id_read;
    (s_axi_arvalid && s_axi_arready && rd_idx == `CWPD_IDX_DEVICE_REV_ID)
      |=> rvalid_q && rdata_q == {18'h00000, DEV_REV_WORD};
  endproperty
  a_device_revision_id_read: assert property (p_device_revision_id_read) else $error("identification word read wrong");

  property p_wdt_off;
    (live && $past(cfg_q[`CWPD_CFG_WDTE_HI:`CWPD_CFG_WDTE_LO]) == `CWPD_MODE_OFF) |-> !watchdog_active;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog active while disabled");

  property p_bor_soft;
    (live && $past(cfg_q[`CWPD_CFG_BOREN_HI:`CWPD_CFG_BOREN_LO]) == `CWPD_MODE_SOFT)
      |-> brownout_active == $past(soft_brownout_enable);
  endproperty
  a_bor_soft: assert property (p_bor_soft) else $error("brown-out does not follow soft enable");

  property p_clk_sel;
    live |-> external_clock_mode == $past(cfg_q[`CWPD_CFG_FOSC]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");

  property p_wrt_all;
    (live && $past(wrt_sel) == `CWPD_WRT_ALL) |-> !self_wr_allow;
  endproperty
  a_wrt_all: assert property (p_wrt_all) else $error("self-write allowed under full protection");

  property p_powerup_timer;
    live |-> powerup_timer_en != $past(cfg_q[`CWPD_CFG_POWERUP_TIMER_EN_N_N]);
  endproperty
  a_powerup_timer: assert property (p_powerup_timer) else $error("power-up timer polarity wrong");

  property p_lvp_reset;
    (live && $past(cfg_q[`CWPD_CFG_LVP])) |-> reset_pin_is_reset && low_voltage_prog_en;
  endproperty
  a_lvp_reset: assert property (p_lvp_reset) else $error("low-voltage programming did not force reset pin");

  sequence s_both_taken;
    aw_held_q && w_held_q && !bvalid_q;
  endsequence
  property p_bresp_follows;
    s_both_taken |=> bvalid_q;
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("write response missing");

endmodule

`default_nettype wire

// ==== logic/cwpd_config_regs.svh ====
// Purpose: offsets, field positions, reset values and codes of the configuration decoder
// Assumes: register index = byte address bits [15:2]; byte address = 4 x index
// Notes:   definitions only
`ifndef CWPD_CONFIG_REGS_SVH
`define CWPD_CONFIG_REGS_SVH

// register indices
`define CWPD_IDX_USER_ID0      14'h2000
`define CWPD_IDX_USER_ID3      14'h2003
`define CWPD_IDX_DEVICE_REV_ID 14'h2006
`define CWPD_IDX_CONFIG_WORD   14'h2007
`define CWPD_IDX_PROG_CONTROL  14'h2008
`define CWPD_IDX_ACTIVE_CONFIG 14'h2009

// configuration word fields
`define CWPD_CFG_UNIMP          13
`define CWPD_CFG_WRT_HI         12
`define CWPD_CFG_WRT_LO         11
`define CWPD_CFG_BROWNOUT_TRIP_SELECT           10
`define CWPD_CFG_LOW_POWER_BROWNOUT_EN          9
`define CWPD_CFG_LVP            8
`define CWPD_CFG_CP_N           7
`define CWPD_CFG_RESET_PIN_FUNCTION_SEL          6
`define CWPD_CFG_POWERUP_TIMER_EN_N_N        5
`define CWPD_CFG_WDTE_HI        4
`define CWPD_CFG_WDTE_LO        3
`define CWPD_CFG_BOREN_HI       2
`define CWPD_CFG_BOREN_LO       1
`define CWPD_CFG_FOSC           0

// program control fields
`define CWPD_PC_PROG_MODE       0
`define CWPD_PC_BULK_ERASE      1

// erased values of the non-volatile cells
`define CWPD_CFG_ERASED         14'h3FFF
`define CWPD_UID_ERASED         14'h3FFF

// two-bit enable mode codes
`define CWPD_MODE_ON            2'h3
`define CWPD_MODE_RUN_ONLY      2'h2
`define CWPD_MODE_SOFT          2'h1
`define CWPD_MODE_OFF           2'h0

// self-write protection codes
`define CWPD_WRT_OFF            2'h3
`define CWPD_WRT_QUARTER        2'h2
`define CWPD_WRT_HALF           2'h1
`define CWPD_WRT_ALL            2'h0

// axi responses
`define CWPD_RESP_OKAY          2'h0
`define CWPD_RESP_SLVERR        2'h2

`endif

// ==== logic/cwpd_pkg.sv ====
// Purpose: types shared by the configuration decoder
// Assumes: nothing beyond the register header
// Notes:   states follow a Gray path load -> settle -> run <-> prog
package cwpd_pkg;

  typedef enum logic [1:0] {
    CWPD_ST_LOAD   = 2'h0,
    CWPD_ST_SETTLE = 2'h1,
    CWPD_ST_RUN    = 2'h3,
    CWPD_ST_PROG   = 2'h2
  } cwpd_state_t;

endpackage

// ==== verif/cwpd_config_decode_tb.sv ====
// Purpose: bench for the configuration decoder
// Assumes: MEM_WORDS 256
// Notes:   expected values from a behavioural decode
`include "cwpd_config_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cwpd_config_decode_tb;
  // arbitrary identification values
  localparam logic [8:0] DEV_CODE = 9'h05A;
  localparam logic [4:0] REV_CODE = 5'h03;
  localparam int         LIMIT    = 6000;
  localparam logic [1:0] OK       = `CWPD_RESP_OKAY;
  logic        aclk, aresetn, cpu_sleep, soft_watchdog_enable, soft_brownout_enable, pin3_pullup_enable;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, self_wr_allow, sys_reset_n;
  logic        brownout_trip_low, low_power_brownout_en, low_voltage_prog_en, reset_pin_is_reset;
  logic        reset_pin_pullup_en, powerup_timer_en, watchdog_active, brownout_active;
  logic        external_clock_mode, ext_write_allow, ext_read_zero;
  logic [15:0] s_axi_awaddr, s_axi_araddr, seed;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [13:0] nv_config_word, c;
  logic [13:0] uid [4];
  logic [7:0]  self_wr_addr;
  logic [10:0] outs;
  int          err_total, samples_checked, cycles, i;
  int          adr [$] = '{'h0, 'h3F, 'h40, 'h7F, 'h80, 'hFF};
  assign outs = {brownout_trip_low, low_power_brownout_en, low_voltage_prog_en, reset_pin_is_reset,
                 reset_pin_pullup_en, powerup_timer_en, watchdog_active, brownout_active,
                 external_clock_mode, ext_write_allow, ext_read_zero};
  cwpd_config_decode #(.MEM_WORDS(256), .DEVICE_CODE(DEV_CODE), .REVISION(REV_CODE)) cwpd_config_decode_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .nv_config_word, .cpu_sleep, .soft_watchdog_enable,
    .soft_brownout_enable, .pin3_pullup_enable, .self_wr_addr, .self_wr_allow, .sys_reset_n,
    .brownout_trip_low, .low_power_brownout_en, .low_voltage_prog_en, .reset_pin_is_reset,
    .reset_pin_pullup_en, .powerup_timer_en, .watchdog_active, .brownout_active,
    .external_clock_mode, .ext_write_allow, .ext_read_zero);
  cwpd_prog_model cwpd_prog_model_inst (
    .aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  always #5 aclk = ~aclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic mode(input logic [1:0] m, input logic slp, input logic sw);
    return (m == 2'h3) || (m == 2'h2 && !slp) || (m == 2'h1 && sw);
  endfunction
  function automatic logic [10:0] model(input logic [13:0] w, input logic [3:0] lv);
    logic rp;
    rp = w[8] | w[6];
    return {w[10], w[9], w[8], rp, rp | lv[0], !w[5], mode(w[4:3], lv[3], lv[2]), mode(w[2:1], lv[3], lv[1]),
            w[0], w[7], !w[7]};
  endfunction
  function automatic logic allow(input logic [1:0] w, input int a);
    int lim;
    lim = (w == 2'h3) ? 0 : (w == 2'h2) ? 'h40 : (w == 2'h1) ? 'h80 : 'h100;
    return a >= lim;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdx(input logic [13:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    cwpd_prog_model_inst.rd({idx, 2'b00}, d, r);
    chk(d, exp);
    chk(32'(r), 32'(er));
  endtask
  task automatic wrx(input logic [13:0] idx, input logic [13:0] d, input logic [1:0] er);
    logic [1:0] r;
    cwpd_prog_model_inst.wr({idx, 2'b00}, d, r);
    chk(32'(r), 32'(er));
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 40) begin
      @(negedge aclk);
      n++;
    end
    repeat (2) @(negedge aclk);
  endtask
  task automatic load_check(input logic [13:0] w, input logic [3:0] lv);
    @(posedge aclk);
    aresetn <= 1'b0;
    nv_config_word <= w;
    {cpu_sleep, soft_watchdog_enable, soft_brownout_enable, pin3_pullup_enable} <= lv;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    chk(32'(sys_reset_n), 32'h1);
    chk(32'(outs), 32'(model(w, lv)));
    @(posedge aclk);
    nv_config_word <= ~w;
    repeat (3) @(negedge aclk);
    chk(32'(outs), 32'(model(w, lv)));
    rdx(14'h2007, {18'h0, w | 14'h2000}, OK);
    foreach (adr[k]) begin
      @(posedge aclk);
      self_wr_addr <= 8'(adr[k]);
      @(posedge aclk);
      @(negedge aclk);
      chk(32'(self_wr_allow), 32'(allow(w[12:11], adr[k])));
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {aclk, aresetn, cpu_sleep, soft_watchdog_enable, soft_brownout_enable, pin3_pullup_enable} = 6'h00;
    nv_config_word = `CWPD_CFG_ERASED;
    self_wr_addr = 8'h00;
    seed = 16'hBCBF;
    {err_total, samples_checked, cycles} = 0;
    load_check(14'h3FFF, 4'h0);
    rdx(14'h2006, {18'h0, DEV_CODE, REV_CODE}, OK);
    wrx(14'h2006, 14'h0000, OK);
    rdx(14'h2006, {18'h0, DEV_CODE, REV_CODE}, OK);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      uid[i] = seed[13:0];
      wrx(14'h2000 + 14'(i), uid[i], OK);
    end
    for (i = 0; i < 4; i++) rdx(14'h2000 + 14'(i), {18'h0, uid[i]}, OK);
    rdx(14'h2005, 32'h0, `CWPD_RESP_SLVERR);
    wrx(14'h2004, 14'h0000, `CWPD_RESP_SLVERR);
    $display("register map test done");
    wrx(14'h2007, 14'h0000, OK);
    rdx(14'h2007, 32'h3FFF, OK);
    wrx(14'h2008, 14'h0001, OK);
    wrx(14'h2007, 14'h3F7F, OK);
    wrx(14'h2008, 14'h0000, OK);
    wait_run();
    chk(32'({ext_read_zero, ext_write_allow}), 32'h2);
    rdx(14'h2009, 32'h3F7F, OK);
    wrx(14'h2008, 14'h0001, OK);
    wrx(14'h2007, 14'h3FFF, OK);
    rdx(14'h2007, 32'h3F7F, OK);
    wrx(14'h2008, 14'h0003, OK);
    wrx(14'h2008, 14'h0000, OK);
    wait_run();
    rdx(14'h2007, 32'h3FFF, OK);
    rdx(14'h2000, 32'h3FFF, OK);
    chk(32'({ext_read_zero, ext_write_allow}), 32'h1);
    $display("programming test done");
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      c = seed[13:0];
      c[12:11] = 2'(i);
      c[4:3] = 2'(i);
      c[2:1] = 2'(i >> 1);
      load_check(c, seed[15:12]);
    end
    $display("decode sweep test done");
    end_sim();
  end
endmodule
`default_nettype wire

// ==== verif/cwpd_prog_model.sv ====
// Purpose: programmer side AXI4-Lite master
// Assumes: one access at a time
// Notes:   handshakes sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module cwpd_prog_model (
  // clock
  input  wire logic        aclk,
  // write address and data
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [15:0]      s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  // write response
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // read channels
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [15:0]      s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
  end
  // released payload inverted: late samples fail
  task automatic wr(input logic [15:0] a, input logic [13:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {18'h0, d};
    s_axi_wstrb   <= 4'h3;
    s_axi_bready  <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid && s_axi_bready;
      r     = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (w_hs) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~{18'h0, d};
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs  = s_axi_rvalid && s_axi_rready;
      d     = s_axi_rdata;
      r     = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire
